// *** design/crs_core_regs.sv ***
/*
 Core register set: instruction counter, working register, auxiliary
 register, ALU status word, stack pointer, two data pointers and the
 pointer control register. Assumes the execution datapath shares the core
 clock and drives one request kind per cycle; register port access from
 software is lower priority than datapath updates of the same register.
*/
// Functional notes
// RQ1: Instruction counter 16 bits, resets to zero.
// RQ2: Alternate vector option starts at configured address.
// RQ3: Working register feeds ALU, takes results.
// RQ4: Auxiliary register for multiply/divide, else general.
// RQ5: Status bit 7 is carry/borrow flag.
// RQ6: Status bit 6 is half-carry flag.
// RQ7: Status bits 4-3 choose the register bank.
// RQ8: Status bit 2 is overflow flag.
// RQ9: Status bit 0 read-only working parity.
// RQ10: Stack pointer 8 bits, resets to 07h.
// RQ11: Push return address low then high, upward.
// RQ12: Data pointer is high and low byte.
// RQ13: Two data pointers, bit 0 chooses one.
// RQ14: Control bit 4 steers code reads target.
// RQ15: Control bits 7-5, 3-1 read zero.
// RQ16: Software sets target bit before option reads.
// RQ17: Status bits 5,1 plain storage, reset zero.
// RQ18: Status write keeps parity following working register.
`timescale 1ns/1ps

module crs_core_regs (
   input  wire logic                 core_clk_in,
   input  wire logic                 nrst_in,
   // Start vector option
   input  wire logic                 alt_vector_en_in,
   input  wire logic [15:0]          alt_vector_addr_in,
   // Register port
   input  wire logic [3:0]           reg_addr_in,
   input  wire logic [7:0]           reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output      logic [7:0]           reg_rdata_out,
   // Datapath updates
   input  wire crs_pkg::crs_flags_t  flags_in,
   input  wire crs_pkg::crs_result_t result_in,
   input  wire logic                 icnt_load_in,
   input  wire logic [15:0]          icnt_target_in,
   input  wire logic                 icnt_step_in,
   input  wire logic                 push_ret_in,
   input  wire logic                 data_pointer_load_in,
   input  wire logic [15:0]          data_pointer_value_in,
   // State views
   output      logic [15:0]          icnt_out,
   output      logic [7:0]           work_out,
   output      logic [7:0]           aux_out,
   output      logic [7:0]           status_out,
   output      logic [7:0]           stack_ptr_out,
   output      logic [15:0]          data_pointer_out,
   output      logic [7:0]           bank_base_out,
   output      logic                 code_sel_out,
   // Stack write strobe toward internal RAM
   output      logic                 stack_we_out,
   output      logic [7:0]           stack_addr_out,
   output      logic [7:0]           stack_data_out
);
   import crs_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [15:0] icnt_q,   icnt_d;
   logic [7:0]  work_q,   work_d;
   logic [7:0]  aux_q,    aux_d;
   logic [7:0]  stat_q,   stat_d;
   logic [7:0]  sp_q,     sp_d;
   logic [15:0] dp0_q,    dp0_d;
   logic [15:0] dp1_q,    dp1_d;
   logic [7:0]  ctrl_q,   ctrl_d;
   logic        push_hi_q, push_hi_d;
   logic        start_q,  start_d;
   logic        swe_q,    swe_d;
   logic [7:0]  sadr_q,   sadr_d;
   logic [7:0]  sdat_q,   sdat_d;
   logic [7:0]  rdata_q,  rdata_d;
   logic        parity;
   logic [15:0] dp_sel;
   logic        wr_at;

   // Parity is combinational so it never lags the working register
   assign parity = ^work_q; // [RQ9]
   assign dp_sel = ctrl_q[CRS_BIT_PTR_CHOICE] ? dp1_q : dp0_q; // [RQ13]

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      icnt_d    = icnt_q;
      work_d    = work_q;
      aux_d     = aux_q;
      stat_d    = stat_q;
      sp_d      = sp_q;
      dp0_d     = dp0_q;
      dp1_d     = dp1_q;
      ctrl_d    = ctrl_q;
      push_hi_d = 1'b0;
      start_d   = 1'b0;
      swe_d     = 1'b0;
      sadr_d    = sadr_q;
      sdat_d    = sdat_q;
      rdata_d   = 8'h00;
      wr_at     = reg_wr_in;

      // Software writes first; datapath updates below override them
      if (wr_at) begin
         unique case (reg_addr_in)
            CRS_IDX_WORK:      work_d = reg_wdata_in; // [RQ3]
            CRS_IDX_AUX:       aux_d  = reg_wdata_in; // [RQ4]
            CRS_IDX_STATUS:    stat_d = reg_wdata_in & CRS_STATUS_WMASK; // [RQ17] [RQ18]
            CRS_IDX_STACK:     sp_d   = reg_wdata_in;
            CRS_IDX_DATA_POINTER_LOW: begin
               if (ctrl_q[CRS_BIT_PTR_CHOICE]) dp1_d[7:0] = reg_wdata_in; // [RQ12]
               else dp0_d[7:0] = reg_wdata_in;
            end
            CRS_IDX_DATA_POINTER_HIGH: begin
               if (ctrl_q[CRS_BIT_PTR_CHOICE]) dp1_d[15:8] = reg_wdata_in; // [RQ12]
               else dp0_d[15:8] = reg_wdata_in;
            end
            CRS_IDX_PTR_CTRL:  ctrl_d = reg_wdata_in & CRS_CTRL_WMASK; // [RQ15] [RQ14]
            default: ;
         endcase
      end

      // Datapath result and flag updates
      if (result_in.work_we) work_d = result_in.work; // [RQ3]
      if (result_in.aux_we)  aux_d  = result_in.aux;  // [RQ4]
      if (flags_in.carry_we)  stat_d[CRS_BIT_CARRY]  = flags_in.carry;  // [RQ5]
      if (flags_in.half_we)   stat_d[CRS_BIT_HALF]   = flags_in.half;   // [RQ6]
      if (flags_in.excess_we) stat_d[CRS_BIT_EXCESS] = flags_in.excess; // [RQ8]
      stat_d[CRS_BIT_PARITY] = 1'b0; // Stored bit unused, parity read live
      if (data_pointer_load_in) begin
         if (ctrl_q[CRS_BIT_PTR_CHOICE]) dp1_d = data_pointer_value_in; // [RQ13]
         else dp0_d = data_pointer_value_in;
      end

      // Instruction counter: first cycle after reset picks the vector
      if (!start_q) begin
         start_d = 1'b1;
         icnt_d  = alt_vector_en_in ? alt_vector_addr_in : CRS_ICNT_RESET; // [RQ2]
      end else begin
         start_d = 1'b1;
         if (icnt_load_in) icnt_d = icnt_target_in;
         else if (icnt_step_in) icnt_d = icnt_q + 16'h0001;
      end

      // Two-cycle push: low byte then high byte, pointer rising each time
      if (push_hi_q) begin
         sp_d   = sp_q + 8'h01; // [RQ11]
         sadr_d = sp_q + 8'h01;
         sdat_d = icnt_q[15:8];
         swe_d  = 1'b1;
      end else if (push_ret_in) begin
         sp_d      = sp_q + 8'h01; // [RQ11]
         sadr_d    = sp_q + 8'h01;
         sdat_d    = icnt_q[7:0];
         swe_d     = 1'b1;
         push_hi_d = 1'b1;
      end

      // Read data stands one cycle after the strobe
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            CRS_IDX_WORK:      rdata_d = work_q;
            CRS_IDX_AUX:       rdata_d = aux_q;
            CRS_IDX_STATUS:    rdata_d = {stat_q[7:1], parity}; // [RQ9]
            CRS_IDX_STACK:     rdata_d = sp_q;
            CRS_IDX_DATA_POINTER_LOW:  rdata_d = dp_sel[7:0];
            CRS_IDX_DATA_POINTER_HIGH: rdata_d = dp_sel[15:8];
            CRS_IDX_PTR_CTRL:  rdata_d = ctrl_q & CRS_CTRL_WMASK; // [RQ15]
            CRS_IDX_ICNT_LOW:  rdata_d = icnt_q[7:0];
            CRS_IDX_ICNT_HIGH: rdata_d = icnt_q[15:8];
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         icnt_q    <= CRS_ICNT_RESET; // [RQ1]
         work_q    <= CRS_WORD_RESET;
         aux_q     <= CRS_WORD_RESET;
         stat_q    <= CRS_STATUS_RESET; // [RQ17]
         sp_q      <= CRS_STACK_RESET; // [RQ10]
         dp0_q     <= CRS_DATA_POINTER_RESET;
         dp1_q     <= CRS_DATA_POINTER_RESET;
         ctrl_q    <= CRS_CTRL_RESET;
         push_hi_q <= 1'b0;
         start_q   <= 1'b0;
         swe_q     <= 1'b0;
         sadr_q    <= 8'h00;
         sdat_q    <= 8'h00;
         rdata_q   <= 8'h00;
      end else begin
         icnt_q    <= icnt_d;
         work_q    <= work_d;
         aux_q     <= aux_d;
         stat_q    <= stat_d;
         sp_q      <= sp_d;
         dp0_q     <= dp0_d;
         dp1_q     <= dp1_d;
         ctrl_q    <= ctrl_d;
         push_hi_q <= push_hi_d;
         start_q   <= start_d;
         swe_q     <= swe_d;
         sadr_q    <= sadr_d;
         sdat_q    <= sdat_d;
         rdata_q   <= rdata_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata_out  = rdata_q;
   assign icnt_out       = icnt_q;
   assign work_out       = work_q;
   assign aux_out        = aux_q;
   assign status_out     = {stat_q[7:1], parity};
   assign stack_ptr_out  = sp_q;
   assign data_pointer_out       = dp_sel;
   // Bank base is bank number times eight
   assign bank_base_out  = {3'b000, stat_q[CRS_BIT_BANK_HI:CRS_BIT_BANK_LO], 3'b000}; // [RQ7]
   assign code_sel_out   = ctrl_q[CRS_BIT_CODE_SEL]; // [RQ14] [RQ16]
   assign stack_we_out   = swe_q;
   assign stack_addr_out = sadr_q;
   assign stack_data_out = sdat_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_parity;
      @(posedge core_clk_in) disable iff (!nrst_in)
         result_in.work_we |=> status_out[CRS_BIT_PARITY] == ^$past(result_in.work);
   endproperty
   a_parity: assert property (p_parity) else $error("parity wrong"); // [RQ9]

   property p_ctrl_zero;
      @(posedge core_clk_in) disable iff (!nrst_in) (ctrl_q & ~CRS_CTRL_WMASK) == 8'h00;
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("control reserved set"); // [RQ15]

   property p_push;
      @(posedge core_clk_in) disable iff (!nrst_in)
         (push_ret_in && !push_hi_q) |=> stack_we_out && stack_addr_out == $past(sp_q) + 8'h01
            ##1 stack_we_out && stack_addr_out == $past(sp_q, 2) + 8'h02;
   endproperty
   a_push: assert property (p_push) else $error("push order wrong"); // [RQ11]

   property p_carry;
      @(posedge core_clk_in) disable iff (!nrst_in) flags_in.carry_we |=> status_out[7] == $past(flags_in.carry);
   endproperty
   a_carry: assert property (p_carry) else $error("carry not taken"); // [RQ5]

   property p_half;
      @(posedge core_clk_in) disable iff (!nrst_in) flags_in.half_we |=> status_out[6] == $past(flags_in.half);
   endproperty
   a_half: assert property (p_half) else $error("half carry not taken"); // [RQ6]

   property p_excess;
      @(posedge core_clk_in) disable iff (!nrst_in) flags_in.excess_we |=> status_out[2] == $past(flags_in.excess);
   endproperty
   a_excess: assert property (p_excess) else $error("overflow not taken"); // [RQ8]

   property p_start;
      @(posedge core_clk_in) disable iff (!nrst_in)
         !start_q |=> icnt_out == ($past(alt_vector_en_in) ? $past(alt_vector_addr_in) : 16'h0000);
   endproperty
   a_start: assert property (p_start) else $error("start vector wrong"); // [RQ1] [RQ2]

   property p_bank;
      @(posedge core_clk_in) disable iff (!nrst_in) (reg_wr_in && reg_addr_in == CRS_IDX_STATUS)
         |=> bank_base_out == {3'b000, $past(reg_wdata_in[CRS_BIT_BANK_HI:CRS_BIT_BANK_LO]), 3'b000};
   endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong"); // [RQ7]

   // Counter moves only after the vector cycle; a load beats a step
   property p_icnt_step;
      @(posedge core_clk_in) disable iff (!nrst_in)
         (start_q && icnt_step_in && !icnt_load_in) |=> icnt_out == $past(icnt_out) + 16'h0001;
   endproperty
   a_icnt_step: assert property (p_icnt_step) else $error("counter step wrong"); // [RQ1]

   property p_icnt_load;
      @(posedge core_clk_in) disable iff (!nrst_in)
         (start_q && icnt_load_in) |=> icnt_out == $past(icnt_target_in);
   endproperty
   a_icnt_load: assert property (p_icnt_load) else $error("counter load wrong"); // [RQ1]

   property p_ctrl_write;
      @(posedge core_clk_in) disable iff (!nrst_in) (reg_wr_in && reg_addr_in == CRS_IDX_PTR_CTRL)
         |=> code_sel_out == $past(reg_wdata_in[CRS_BIT_CODE_SEL]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("code read target not taken"); // [RQ14]

   property p_data_pointer_load;
      @(posedge core_clk_in) disable iff (!nrst_in)
         (data_pointer_load_in && !(reg_wr_in && reg_addr_in == CRS_IDX_PTR_CTRL)) |=> data_pointer_out == $past(data_pointer_value_in);
   endproperty
   a_data_pointer_load: assert property (p_data_pointer_load) else $error("pointer load wrong"); // [RQ13]

   // Checked at the first edge after release, before any request lands
   property p_reset_vals;
      @(posedge core_clk_in) $rose(nrst_in) |->
         icnt_out == CRS_ICNT_RESET && stack_ptr_out == CRS_STACK_RESET && status_out == CRS_STATUS_RESET;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong"); // [RQ1] [RQ10] [RQ17]

endmodule

// *** design/crs_pkg.sv ***
/*
 Package for the core register set: register indexes, field positions,
 reset values and the carrier structs shared by the block and its users.
 Assumes a single core clock domain and an 8-bit register port.
*/
package crs_pkg;

   // ------------------------------------------------------------
   // Register indexes on the register port
   // ------------------------------------------------------------
   localparam logic [3:0] CRS_IDX_WORK      = 4'h0;
   localparam logic [3:0] CRS_IDX_AUX       = 4'h1;
   localparam logic [3:0] CRS_IDX_STATUS    = 4'h2;
   localparam logic [3:0] CRS_IDX_STACK     = 4'h3;
   localparam logic [3:0] CRS_IDX_DATA_POINTER_LOW  = 4'h4;
   localparam logic [3:0] CRS_IDX_DATA_POINTER_HIGH = 4'h5;
   localparam logic [3:0] CRS_IDX_PTR_CTRL  = 4'h6;
   localparam logic [3:0] CRS_IDX_ICNT_LOW  = 4'h7;
   localparam logic [3:0] CRS_IDX_ICNT_HIGH = 4'h8;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CRS_BIT_CARRY     = 7;
   localparam int CRS_BIT_HALF      = 6;
   localparam int CRS_BIT_USER0     = 5;
   localparam int CRS_BIT_BANK_HI   = 4;
   localparam int CRS_BIT_BANK_LO   = 3;
   localparam int CRS_BIT_EXCESS    = 2;
   localparam int CRS_BIT_USER1     = 1;
   localparam int CRS_BIT_PARITY    = 0;
   localparam int CRS_BIT_CODE_SEL  = 4;
   localparam int CRS_BIT_PTR_CHOICE = 0;

   // ------------------------------------------------------------
   // Reset values and masks
   // ------------------------------------------------------------
   localparam logic [15:0] CRS_ICNT_RESET    = 16'h0000;
   localparam logic [7:0]  CRS_STATUS_RESET  = 8'h00;
   localparam logic [7:0]  CRS_STACK_RESET   = 8'h07;
   localparam logic [15:0] CRS_DATA_POINTER_RESET    = 16'h0000;
   localparam logic [7:0]  CRS_CTRL_RESET    = 8'h00;
   localparam logic [7:0]  CRS_CTRL_WMASK    = 8'h11;
   localparam logic [7:0]  CRS_STATUS_WMASK  = 8'hfe;
   localparam logic [7:0]  CRS_WORD_RESET    = 8'h00;
   localparam logic [7:0]  CRS_BANK_SIZE     = 8'h08;

   // ALU flag update from the datapath
   typedef struct packed {
      logic       carry_we;
      logic       carry;
      logic       half_we;
      logic       half;
      logic       excess_we;
      logic       excess;
   } crs_flags_t;

   // Working and auxiliary register update from the datapath
   typedef struct packed {
      logic       work_we;
      logic [7:0] work;
      logic       aux_we;
      logic [7:0] aux;
   } crs_result_t;

endpackage

// *** tb/crs_core_regs_tb.sv ***
/*
 Self-checking bench for the core register set with a datapath model.
 Assumes the 40 MHz core clock and reads answered one cycle late.
*/
`timescale 1ns/1ps

module crs_core_regs_tb;
   import crs_pkg::*;

   logic core_clk_in = 1'b0, nrst_in = 1'b0, alt_en = 1'b0, wr = 1'b0, rd_s = 1'b0;
   logic [15:0] alt_addr = 16'h0000, icnt, data_pointer, va, t;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, work, aux, status, sp_o, bank, st_a, st_d, w, a, v, sp;
   logic code_sel, st_we, ld, step, push, dl, rd_seen = 1'b0;
   logic [15:0] tgt, dval;
   crs_flags_t flags;
   crs_result_t res;
   logic [7:0] rd_q[$];
   logic [15:0] st_q[$];
   integer seed = 32'hf9d43036, miscompares = 0, n_checks = 0, cycles = 0;

   always #12.5 core_clk_in = ~core_clk_in;

   crs_datapath_model dp (.core_clk_in(core_clk_in), .flags_out(flags), .result_out(res),
      .icnt_load_out(ld), .icnt_target_out(tgt), .icnt_step_out(step), .push_ret_out(push),
      .data_pointer_load_out(dl), .data_pointer_value_out(dval));

   crs_core_regs dut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .alt_vector_en_in(alt_en),
      .alt_vector_addr_in(alt_addr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd_s), .reg_rdata_out(rdata), .flags_in(flags), .result_in(res),
      .icnt_load_in(ld), .icnt_target_in(tgt), .icnt_step_in(step), .push_ret_in(push),
      .data_pointer_load_in(dl), .data_pointer_value_in(dval), .icnt_out(icnt), .work_out(work), .aux_out(aux),
      .status_out(status), .stack_ptr_out(sp_o), .data_pointer_out(data_pointer), .bank_base_out(bank),
      .code_sel_out(code_sel), .stack_we_out(st_we), .stack_addr_out(st_a), .stack_data_out(st_d));

   // ------------------------------------------------------------
   // Compare, report and register port tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Register port read data
   task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
      chk({8'h00, got}, {8'h00, exp});
   endtask

   // Stack write: address and data together
   task automatic chk_st(input logic [15:0] got, input logic [15:0] exp);
      chk(got, exp);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
      @(posedge core_clk_in);
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
   endtask

   // Expected data is queued before the strobe so the watcher finds it
   task automatic rd_reg(input logic [3:0] ad, input logic [7:0] e);
      rd_q.push_back(e);
      @(posedge core_clk_in);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge core_clk_in);
      rd_s <= 1'b0;
   endtask

   task automatic settle;
      @(negedge core_clk_in);
   endtask

   // Watcher: read data one cycle after the strobe, stack writes as they come
   always @(negedge core_clk_in) begin
      if (rd_seen) chk_rd(rdata, rd_q.pop_front());
      rd_seen = rd_s;
      if (st_we === 1'b1) chk_st({st_a, st_d}, st_q.pop_front());
   end

   // Hang guard: far above the 164 cycles the run needs
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         report_and_stop;
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      settle;
      chk(icnt, 16'h0000);
      chk({8'h00, sp_o}, 16'h0007);
      for (int i = 0; i < 10; i++) rd_reg(i[3:0], (i == 3) ? 8'h07 : 8'h00);
      wr_reg(4'h7, 8'hff);
      rd_reg(4'h7, 8'h00);
      $display("test reset done");
      va = 16'($random(seed));
      alt_en <= 1'b1;
      alt_addr <= va;
      nrst_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      // Vector is taken at the first edge after release, not before
      @(posedge core_clk_in);
      alt_en <= 1'b0;
      settle;
      chk(icnt, va);
      rd_reg(4'h8, va[15:8]);
      dp.counter(1'b0, 16'h0000, 1'b1);
      settle;
      chk(icnt, va + 16'h0001);
      $display("test start vector done");
      for (int i = 0; i < 6; i++) begin
         w = 8'($random(seed));
         a = 8'($random(seed));
         dp.result({1'b1, w, 1'b1, a});
         settle;
         chk({8'h00, work}, {8'h00, w});
         chk({8'h00, aux}, {8'h00, a});
         chk({15'h0000, status[0]}, {15'h0000, ^w});
         wr_reg(4'h1, ~a);
         rd_reg(4'h1, ~a);
      end
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         v[4:3] = i[1:0];
         w = 8'($random(seed));
         wr_reg(4'h0, w);
         wr_reg(4'h2, v);
         rd_reg(4'h2, {v[7:1], ^w});
         settle;
         chk({8'h00, bank}, {8'h00, 3'h0, v[4:3], 3'h0});
      end
      wr_reg(4'h2, 8'h00);
      for (int i = 0; i < 8; i++) begin
         dp.flag({1'b1, i[2], 1'b1, i[1], 1'b1, i[0]});
         settle;
         chk({13'h0000, status[7], status[6], status[2]}, {13'h0000, i[2:0]});
      end
      $display("test work and status done");
      // Target select set before any option-area read is issued
      wr_reg(4'h6, 8'hff);
      rd_reg(4'h6, 8'h11);
      settle;
      chk({15'h0000, code_sel}, 16'h0001);
      wr_reg(4'h4, 8'h3c);
      wr_reg(4'h5, 8'hc3);
      wr_reg(4'h6, 8'h00);
      wr_reg(4'h4, 8'h5a);
      wr_reg(4'h5, 8'ha5);
      settle;
      chk(data_pointer, 16'ha55a);
      chk({15'h0000, code_sel}, 16'h0000);
      wr_reg(4'h6, 8'h01);
      rd_reg(4'h4, 8'h3c);
      settle;
      chk(data_pointer, 16'hc33c);
      t = 16'($random(seed));
      dp.dload(t);
      wr_reg(4'h6, 8'h00);
      settle;
      chk(data_pointer, 16'ha55a);
      wr_reg(4'h6, 8'h01);
      settle;
      chk(data_pointer, t);
      $display("test pointers done");
      sp = 8'($random(seed));
      t = 16'($random(seed));
      wr_reg(4'h3, sp);
      // Load and step together: the load must win
      dp.counter(1'b1, t, 1'b1);
      for (int i = 0; i < 2; i++) begin
         st_q.push_back({sp + 8'h01, t[7:0]});
         st_q.push_back({sp + 8'h02, t[15:8]});
         dp.push;
         sp = sp + 8'h02;
      end
      repeat (2) @(posedge core_clk_in);
      settle;
      chk({8'h00, sp_o}, {8'h00, sp});
      rd_reg(4'h3, sp);
      repeat (3) @(posedge core_clk_in);
      $display("test push done");
      report_and_stop;
   end
endmodule

// *** tb/crs_datapath_model.sv ***
/*
 Far-side model of the execution datapath: one-cycle requests on command.
 Assumes one bench process calls its tasks, one task at a time.
*/
`timescale 1ns/1ps

module crs_datapath_model (
   input  wire logic                 core_clk_in,
   output      crs_pkg::crs_flags_t  flags_out,
   output      crs_pkg::crs_result_t result_out,
   output      logic                 icnt_load_out,
   output      logic [15:0]          icnt_target_out,
   output      logic                 icnt_step_out,
   output      logic                 push_ret_out,
   output      logic                 data_pointer_load_out,
   output      logic [15:0]          data_pointer_value_out
);
   import crs_pkg::*;

   // Idle state; released data lines show inverted values, never stale ones
   initial begin
      flags_out = '0;
      result_out = '0;
      icnt_load_out = 1'b0;
      icnt_target_out = 16'h0000;
      icnt_step_out = 1'b0;
      push_ret_out = 1'b0;
      data_pointer_load_out = 1'b0;
      data_pointer_value_out = 16'h0000;
   end

   task automatic flag(input crs_flags_t f);
      @(posedge core_clk_in);
      flags_out <= f;
      @(posedge core_clk_in);
      flags_out <= ~f & 6'h15;
   endtask

   task automatic result(input crs_result_t r);
      @(posedge core_clk_in);
      result_out <= r;
      @(posedge core_clk_in);
      result_out <= ~r & 18'h1feff;
   endtask

   task automatic counter(input logic ld, input logic [15:0] t, input logic st);
      @(posedge core_clk_in);
      icnt_load_out <= ld;
      icnt_target_out <= t;
      icnt_step_out <= st;
      @(posedge core_clk_in);
      icnt_load_out <= 1'b0;
      icnt_step_out <= 1'b0;
      icnt_target_out <= ~t;
   endtask

   // Single push pulse; the next one lands two cycles later at the earliest
   task automatic push;
      @(posedge core_clk_in);
      push_ret_out <= 1'b1;
      @(posedge core_clk_in);
      push_ret_out <= 1'b0;
   endtask

   task automatic dload(input logic [15:0] v);
      @(posedge core_clk_in);
      data_pointer_load_out <= 1'b1;
      data_pointer_value_out <= v;
      @(posedge core_clk_in);
      data_pointer_load_out <= 1'b0;
      data_pointer_value_out <= ~v;
   endtask
endmodule
